// *** rtl/host_port_pkg.sv ***
package host_port_pkg;

   // Host port geometry
   localparam int ADDR_W     = 9;
   localparam int DATA_W     = 16;
   localparam int CTRL_REGS  = 13;
   localparam int COEF_COUNT = 128;
   localparam int SNAP_WORDS = 256;

   // Address map
   localparam logic [8:0] CTRL_LAST     = 9'h00c;
   localparam logic [8:0] EXT_MODE_ADDR = 9'h00c;
   localparam logic [8:0] COEF_BASE     = 9'h080;
   localparam logic [8:0] SNAP_BASE     = 9'h100;

   // Extension register fields
   localparam int INV_AIN_BIT   = 0;
   localparam int INV_BIN_BIT   = 1;
   localparam int INV_AOUT_BIT  = 2;
   localparam int INV_BOUT_BIT  = 3;
   localparam int DET_OFF_BIT   = 4;
   localparam int FORCE_PD_BIT  = 5;
   localparam logic [15:0] EXT_MODE_MASK  = 16'h003f;
   localparam logic [15:0] EXT_MODE_RESET = 16'h0000;
   localparam logic [15:0] CTRL_RESET     = 16'h0000;

   // Snapshot layouts
   localparam logic [1:0] SNAP_TWO_16  = 2'h0;
   localparam logic [1:0] SNAP_TWO_8   = 2'h1;
   localparam logic [1:0] SNAP_ONE_8   = 2'h2;

   // Clock loss: ticks of the slow detector clock with no main edge
   localparam int LOSS_TICKS = 4;

   // Pins as seen by the block
   typedef struct packed {
      logic       cs_n;
      logic       oe_n;
      logic       we_n;
      logic [8:0] addr;
      logic [15:0] data;
   } host_pins_t;

   // Decoded extension controls
   typedef struct packed {
      logic inv_ain;
      logic inv_bin;
      logic inv_aout;
      logic inv_bout;
      logic det_off;
      logic force_pd;
   } ext_mode_t;

endpackage : host_port_pkg

// *** rtl/clock_loss_detect.sv ***
`timescale 1ns/1ps
// Syncs a free running slow tick from outside; power_down never uses it
module clock_loss_detect
   import host_port_pkg::*;
#(
   parameter int TICKS = LOSS_TICKS
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic tick_async,
   input  wire logic det_off,
   input  wire logic force_pd,
   output logic      power_down
);
   logic [2:0] tick_sync_r;
   logic [2:0] tick_sync_nxt;
   logic       alive_r;
   logic       alive_nxt;

   // Sync the slow tick and note that the main clock moved
   always_comb begin
      tick_sync_nxt = {tick_sync_r[1:0], tick_async};
      alive_nxt     = 1'b1;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tick_sync_r <= 3'h0;
         alive_r     <= 1'b0;
      end else begin
         tick_sync_r <= tick_sync_nxt;
         alive_r     <= alive_nxt;
      end
   end

   // Stopped clock: alive_r cannot fall without main edges, so loss is left to the static cell outside; here
   // power_down follows force and a clock that has not yet run since reset
   assign power_down = force_pd | (~det_off & ~alive_r);
endmodule : clock_loss_detect

// *** rtl/filter_host_port.sv ***
`timescale 1ns/1ps
module filter_host_port
   import host_port_pkg::*;
#(
   parameter int COEF_W = 14
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        cs_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [8:0]  addr,
   input  wire logic [15:0] data_in,
   output logic [15:0]      data_out,
   output logic             data_oe,
   input  wire logic        loss_tick,
   input  wire logic [1:0]  snap_layout,
   input  wire logic        snap_we,
   input  wire logic [8:0]  snap_addr,
   input  wire logic [15:0] snap_data,
   input  wire logic [11:0] ain,
   input  wire logic [11:0] bin,
   input  wire logic [23:0] aout_raw,
   input  wire logic [23:0] bout_raw,
   output logic [11:0]      ain_conv,
   output logic [11:0]      bin_conv,
   output logic [23:0]      aout_conv,
   output logic [23:0]      bout_conv,
   output logic [12*16-1:0] ctrl_flat,
   output logic [COEF_W-1:0] coef_rd,
   input  wire logic [6:0]  coef_idx,
   output logic             power_down
);
   // Register state and decode
   host_pins_t  s1_r, s2_r;           // Two-stage pin synchroniser
   logic [15:0] ctrl_r   [0:CTRL_REGS-2];
   logic [15:0] ctrl_nxt [0:CTRL_REGS-2];
   logic [15:0] ext_r,   ext_nxt;
   logic [COEF_W-1:0] coef_r [0:COEF_COUNT-1];
   logic [15:0] snap_r   [0:SNAP_WORDS-1];
   logic [15:0] rd_r,    rd_nxt;
   logic        wr_act, rd_act;
   logic        wr_ext, wr_ctrl, wr_coef;
   logic        coef_we;
   logic [6:0]  coef_waddr;
   logic [COEF_W-1:0] coef_wdata;
   ext_mode_t   ext;

   // Region decode; callers pick out the extension word before the control range
   function automatic logic is_ctrl(input logic [8:0] a);
      return a <= CTRL_LAST;
   endfunction : is_ctrl

   function automatic logic is_coef(input logic [8:0] a);
      return (a >= COEF_BASE) && (a < SNAP_BASE);
   endfunction : is_coef

   // Snapshot read formatting by layout
   // Byte layouts return one sample in the low lane with the upper lane zero
   function automatic logic [15:0] snap_read(input logic [1:0] lay, input logic [8:0] a);
      logic [15:0] w;
      w = snap_r[a[7:0]];
      if (lay == SNAP_TWO_16) begin
         snap_read = w;
      end else if (lay == SNAP_TWO_8) begin
         snap_read = {8'h00, a[7] ? w[15:8] : w[7:0]};
      end else begin
         snap_read = {8'h00, a[8] ? w[15:8] : w[7:0]};
      end
   endfunction : snap_read

   // Pins cross into the clock domain
   // Data rides with the strobes so a write never lands a half-settled word
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s1_r <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 9'h000, data: 16'h0000};
         s2_r <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 9'h000, data: 16'h0000};
      end else begin
         s1_r <= '{cs_n: cs_n, oe_n: oe_n, we_n: we_n, addr: addr, data: data_in};
         s2_r <= s1_r;
      end
   end

   // Strobe decoding for both styles; with output enable grounded the write
   // strobe alone gives the direction, so one decode serves both styles
   always_comb begin
      wr_act  = ~s2_r.cs_n & ~s2_r.we_n;
      rd_act  = ~s2_r.cs_n & s2_r.we_n & ~s2_r.oe_n;
      wr_ext  = wr_act && (s2_r.addr == EXT_MODE_ADDR);
      wr_ctrl = wr_act && is_ctrl(s2_r.addr) && (s2_r.addr != EXT_MODE_ADDR);
      wr_coef = wr_act && is_coef(s2_r.addr);           // Snapshot writes fall through
   end

   // Extension register next value
   // Undefined positions are masked on the way in so they always read zero
   always_comb begin
      ext_nxt = ext_r;
      if (wr_ext) begin
         ext_nxt = s2_r.data & EXT_MODE_MASK;
      end
   end

   // Control register next values; the extension word lives apart
   always_comb begin
      for (int i = 0; i < CTRL_REGS - 1; i++) begin
         ctrl_nxt[i] = ctrl_r[i];
      end
      if (wr_ctrl) begin
         ctrl_nxt[s2_r.addr[3:0]] = s2_r.data;
      end
   end

   // Coefficient write port, the array itself only registers it
   always_comb begin
      coef_we    = wr_coef;
      coef_waddr = s2_r.addr[6:0];
      coef_wdata = s2_r.data[COEF_W-1:0];
   end

   // Read mux over the 512-word space
   // Holes in the map read as zero so probing software sees nothing stray
   always_comb begin
      rd_nxt = 16'h0000;
      if (s2_r.addr == EXT_MODE_ADDR) begin
         rd_nxt = ext_r & EXT_MODE_MASK;
      end else if (is_ctrl(s2_r.addr)) begin
         rd_nxt = ctrl_r[s2_r.addr[3:0]];
      end else if (is_coef(s2_r.addr)) begin
         rd_nxt = 16'(coef_r[s2_r.addr[6:0]]);
      end else if (s2_r.addr[8]) begin
         rd_nxt = snap_read(snap_layout, s2_r.addr);
      end
   end

   // Register storage, latched while the write strobe pair stays low
   // The same word is written again each cycle the strobes stay low
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ext_r <= EXT_MODE_RESET;
         rd_r  <= 16'h0000;
         for (int i = 0; i < CTRL_REGS - 1; i++) begin
            ctrl_r[i] <= CTRL_RESET;
         end
      end else begin
         ext_r <= ext_nxt;
         rd_r  <= rd_nxt;
         for (int i = 0; i < CTRL_REGS - 1; i++) begin
            ctrl_r[i] <= ctrl_nxt[i];
         end
      end
   end

   // Coefficient and snapshot arrays
   // Arrays carry no reset; software loads every coefficient before use
   always_ff @(posedge clock) begin
      if (coef_we) begin
         coef_r[coef_waddr] <= coef_wdata;
      end
      if (snap_we) begin
         snap_r[snap_addr[7:0]] <= snap_data;
      end
   end

   // Extension fields by name
   // Each bit acts directly, no staging between write and effect
   always_comb begin
      ext      = '{inv_ain: ext_r[INV_AIN_BIT], inv_bin: ext_r[INV_BIN_BIT],
                   inv_aout: ext_r[INV_AOUT_BIT], inv_bout: ext_r[INV_BOUT_BIT],
                   det_off: ext_r[DET_OFF_BIT], force_pd: ext_r[FORCE_PD_BIT]};
   end

   // Bus drive; raw pins gate the enable so the bus lets go as soon as the host
   // lifts a strobe, instead of two synchroniser cycles later
   always_comb begin
      data_out = rd_r;
      data_oe  = rd_act & ~cs_n & ~oe_n & we_n;
   end

   // Control and coefficient views for the datapath
   always_comb begin
      for (int i = 0; i < CTRL_REGS - 1; i++) begin
         ctrl_flat[i*16 +: 16] = ctrl_r[i];
      end
      coef_rd  = coef_r[coef_idx];
   end

   // Offset binary conversion on the MSBs
   // Only the top bit flips; the rest of each word passes untouched
   always_comb begin
      ain_conv  = {ain[11] ^ ext.inv_ain, ain[10:0]};
      bin_conv  = {bin[11] ^ ext.inv_bin, bin[10:0]};
      aout_conv = {aout_raw[23] ^ ext.inv_aout, aout_raw[22:0]};
      bout_conv = {bout_raw[23] ^ ext.inv_bout, bout_raw[22:0]};
   end

   // Power-down control
   // Force wins over the detector; detect-off only masks the loss path
   clock_loss_detect u_loss (
      .clock      (clock),
      .rst_n      (rst_n),
      .tick_async (loss_tick),
      .det_off    (ext.det_off),
      .force_pd   (ext.force_pd),
      .power_down (power_down)
   );
endmodule : filter_host_port

// *** tb/host_port_properties.sv ***
`timescale 1ns/1ps
// Pin and conversion checks at the port
module host_port_checker (
   input wire logic         clock,
   input wire logic         rst_n,
   input wire logic         cs_n,
   input wire logic         oe_n,
   input wire logic         we_n,
   input wire logic         data_oe,
   input wire logic [11:0]  ain,
   input wire logic [23:0]  aout_raw,
   input wire logic [11:0]  ain_conv,
   input wire logic [23:0]  aout_conv,
   input wire logic [191:0] ctrl_flat
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Read strobes low, host idle, and the properties built on them
   sequence s_rd; !cs_n && !oe_n && we_n; endsequence
   sequence s_idle; cs_n [*4]; endsequence
   property p_oe_on; s_rd [*4] |-> data_oe; endproperty
   property p_cs_off; s_idle |-> !data_oe; endproperty
   property p_oe_off; oe_n [*4] |-> !data_oe; endproperty
   property p_we_off; !we_n [*4] |-> !data_oe; endproperty
   property p_ctrl; s_idle |=> $stable(ctrl_flat); endproperty
   property p_inv; s_idle |=> $stable(ain_conv[11] ^ ain[11]) && $stable(aout_conv[23] ^ aout_raw[23]); endproperty
   property p_low; ain_conv[10:0] == ain[10:0] && aout_conv[22:0] == aout_raw[22:0]; endproperty
   property p_rst; $rose(rst_n) |-> ain_conv == ain && aout_conv == aout_raw; endproperty
   // Assertions
   a_oe_on: assert property (p_oe_on) else $error("read not driven");
   a_cs_off: assert property (p_cs_off) else $error("driven unselected");
   a_oe_off: assert property (p_oe_off) else $error("driven without oe");
   a_we_off: assert property (p_we_off) else $error("driven in write");
   a_ctrl: assert property (p_ctrl) else $error("control changed idle");
   a_inv: assert property (p_inv) else $error("inversion changed idle");
   a_low: assert property (p_low) else $error("low bits altered");
   a_rst: assert property (p_rst) else $error("inversion set at reset");
endmodule : host_port_checker
bind filter_host_port host_port_checker chk (.clock, .rst_n, .cs_n, .oe_n, .we_n, .data_oe, .ain, .aout_raw,
   .ain_conv, .aout_conv, .ctrl_flat);

// *** tb/host_model.sv ***
`timescale 1ns/1ps
// Host processor on the strobe port
module host_model (
   input  wire logic        clock,
   input  wire logic        rw,
   input  wire logic [15:0] data_out,
   input  wire logic        data_oe,
   output logic             cs_n,
   output logic             oe_n,
   output logic             we_n,
   output logic [8:0]       addr,
   output logic [15:0]      data_in,
   output logic             tmo
);
   logic        oe_r;
   logic [15:0] drv;
   // Grounded oe_n selects direction style; bus shows device drive, else host pattern
   assign oe_n = rw ? 1'b0 : oe_r;
   assign data_in = data_oe ? data_out : drv;
   initial {cs_n, oe_r, we_n, tmo, addr, drv} = 29'h1c005a5a;
   // One transfer; strobes and data held past the sync delay, released bus flips
   task automatic xfer(input logic w, input logic [8:0] a, inout logic [15:0] d);
      int n = 0;
      @(negedge clock);
      addr = a;
      drv = w ? d : ~drv;
      cs_n = 1'b0;
      we_n = !w;
      oe_r = w;
      while (!w && data_oe !== 1'b1 && n < 8) begin
         @(negedge clock);
         n++;
      end
      tmo = (n == 8);
      repeat (5) @(negedge clock);
      if (!w) d = data_in;
      {cs_n, we_n, oe_r} = 3'h7;
      repeat (2) @(negedge clock);
      drv = ~drv;
      repeat (4) @(negedge clock);
   endtask : xfer
endmodule : host_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
// Host model on the port, results checked by a monitor
module testbench;
   import host_port_pkg::*;
   logic         clock, rst_n, cs_n, oe_n, we_n, data_oe, power_down, tmo, rw;
   logic         loss_tick = 1'b0;
   logic         snap_we;
   logic [1:0]   snap_layout;
   logic [8:0]   addr, snap_addr;
   logic [6:0]   coef_idx;
   logic [13:0]  coef_rd;
   logic [15:0]  data_in, data_out, v, r, seen_v, snap_data;
   logic [11:0]  ain, bin, ain_conv, bin_conv;
   logic [23:0]  aout_raw, bout_raw, aout_conv, bout_conv;
   logic [191:0] ctrl_flat;
   logic [15:0]  exp_q[$];
   string        nm_q[$];
   int           n_fail = 0;
   int           total_checks = 0;
   event         seen_ev;
   filter_host_port uut (.clock, .rst_n, .cs_n, .oe_n, .we_n, .addr, .data_in, .data_out, .data_oe, .loss_tick,
      .snap_layout, .snap_we, .snap_addr, .snap_data, .ain, .bin, .aout_raw,
      .bout_raw, .ain_conv, .bin_conv, .aout_conv, .bout_conv, .ctrl_flat, .coef_rd, .coef_idx, .power_down);
   host_model host (.clock, .rw, .data_out, .data_oe, .cs_n, .oe_n, .we_n, .addr, .data_in, .tmo);
   // Clock and loss tick
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(negedge clock) loss_tick <= ~loss_tick;
   // Note an expectation and hand the seen value to the monitor
   task automatic note(input string n, input logic [15:0] e, input logic [15:0] s);
      exp_q.push_back(e);
      nm_q.push_back(n);
      seen_v = s;
      -> seen_ev;
      #1;
   endtask : note
   // Compare one value
   task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : check
   // Monitor takes the oldest note for each result
   initial forever begin
      @(seen_ev);
      check(nm_q.pop_front(), seen_v, exp_q.pop_front());
   end
   // Closing report
   task automatic print_verdict;
      if (n_fail == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   always @(posedge tmo) begin
      n_fail++;
      print_verdict();
   end
   // Main sequence
   initial begin
      void'($urandom(9667));
      {rst_n, rw, coef_idx, ain, bin, aout_raw, bout_raw, snap_layout, snap_we, snap_addr, snap_data} = '0;
      repeat (8) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      host.xfer(1'b0, EXT_MODE_ADDR, r);
      note("ext_rst", EXT_MODE_RESET, r);
      for (int i = 0; i < 7; i++) begin
         @(negedge clock);
         v = (i == 6) ? 16'hffff : 16'h0001 << i;
         {ain, bin, aout_raw, bout_raw} = 72'({$urandom, $urandom, $urandom});
         host.xfer(1'b1, EXT_MODE_ADDR, v);
         host.xfer(1'b0, EXT_MODE_ADDR, r);
         note("ext_rd", v & EXT_MODE_MASK, r);
         note("msb", {12'h000, ain[11] ^ v[0], bin[11] ^ v[1], aout_raw[23] ^ v[2], bout_raw[23] ^ v[3]},
              {12'h000, ain_conv[11], bin_conv[11], aout_conv[23], bout_conv[23]});
         note("pd", {15'h0000, v[5]}, {15'h0000, power_down});
      end
      v = 16'($urandom);
      host.xfer(1'b1, 9'h000, v);
      host.xfer(1'b0, 9'h000, r);
      note("ctrl0", v, r);
      note("flat", v, ctrl_flat[15:0]);
      @(negedge clock);
      coef_idx = 7'h05;
      host.xfer(1'b1, COEF_BASE + 9'h005, v);
      note("coef", {2'h0, v[13:0]}, {2'h0, coef_rd});
      host.xfer(1'b1, 9'h00d, v);
      host.xfer(1'b0, 9'h00d, r);
      note("unmap", 16'h0000, r);
      @(negedge clock);
      {snap_we, snap_addr, snap_data} = {1'b1, 9'h105, 16'($urandom)};
      @(negedge clock);
      snap_we = 1'b0;
      host.xfer(1'b0, 9'h105, r);
      note("snap16", snap_data, r);
      host.xfer(1'b1, 9'h105, v);
      host.xfer(1'b0, 9'h105, r);
      note("snap_ro", snap_data, r);
      @(negedge clock);
      snap_layout = SNAP_TWO_8;
      host.xfer(1'b0, 9'h105, r);
      note("snap8", {8'h00, snap_data[7:0]}, r);
      @(negedge clock);
      snap_layout = SNAP_ONE_8;
      host.xfer(1'b0, 9'h105, r);
      note("snap8one", {8'h00, snap_data[15:8]}, r);
      @(negedge clock);
      rw = 1'b1;
      v = 16'h000a;
      host.xfer(1'b1, EXT_MODE_ADDR, v);
      host.xfer(1'b0, EXT_MODE_ADDR, r);
      note("rw", 16'h000a, r);
      @(negedge clock);
      rst_n = 1'b0;
      repeat (8) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      host.xfer(1'b0, EXT_MODE_ADDR, r);
      note("ext_rst2", EXT_MODE_RESET, r);
      print_verdict();
   end
endmodule : testbench
